// File: inc/intc_cfg.svh
/*
 * constants of the interrupt controller core: register offsets, bit positions,
 * reset values and timing figures. assumes nothing; included by bare name.
 */
`ifndef INTC_CFG_SVH
`define INTC_CFG_SVH

// word byte addresses on the avalon slave
`define INTC_ADDR_CTRL 4'h0
`define INTC_ADDR_PFLAG 4'h4
`define INTC_ADDR_PEN 4'h8
`define INTC_ADDR_OPT 4'hc

// control register bit positions
`define INTC_B_GIE 7
`define INTC_B_PEIE 6
`define INTC_B_T0IE 5
`define INTC_B_EIE 4
`define INTC_B_PCIE 3
`define INTC_B_T0IF 2
`define INTC_B_EIF 1
`define INTC_B_PCIF 0
// option register: polarity select
`define INTC_B_EDGE 6
// peripheral reserved bit, converter request
`define INTC_B_ADC 6

`define INTC_CTRL_RST 8'h00
`define INTC_PREG_RST 8'h00
`define INTC_OPT_RST 8'hff
`define INTC_VECTOR 13'h0004
`define INTC_ZERO8 8'h00
`define INTC_PH_LAST 2'h3
`define INTC_PH_FIRST 2'h0
`define INTC_RDATA_DEF 32'h00000000

`endif

// File: inc/intc_pkg.sv
/*
 * types of the interrupt controller core. assumes intc_cfg.svh for numbers.
 */
package intc_pkg;
	typedef enum logic [1:0] {
		INTC_RUN,
		INTC_SLEEP,
		INTC_VEC
	} intc_state_t;
	typedef logic [7:0] intc_byte_t;
endpackage : intc_pkg

// File: verification/intc_core_tb.sv
/* self-checking bench for intc_core: avalon register tasks and event scenarios.
   assumes intc_cpu_model drives the sequencer side of the core. */
`timescale 1ns/1ns
`include "intc_cfg.svh"
module intc_core_tb;
	logic mclk = 1'b0;
	logic rst = 1'b1;
	logic [3:0] avs_address = 4'h0;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h00000000;
	logic [3:0] avs_byteenable = 4'hf;
	logic edge_irq_pin = 1'b0;
	logic [3:0] upper_port_pins = 4'h0;
	logic timer0_wrap = 1'b0;
	logic [7:0] periph_event = 8'h00;
	logic do_sleep = 1'b0;
	logic do_return = 1'b0;
	logic [31:0] avs_readdata;
	logic avs_waitrequest, vector_req, push_stack, wake_up, sleeping, sleep_enter, ret;
	logic [12:0] vector_pc, push_pc, return_pc, exp_push;
	logic [1:0] phase;
	logic [7:0] rd;
	int fails = 0;
	int check_count = 0;
	int n_vec = 0;
	int n_wake = 0;
	always #25 mclk = ~mclk;
	always @(posedge mclk) begin
		n_vec <= n_vec + int'(vector_req === 1'b1);
		n_wake <= n_wake + int'(wake_up === 1'b1);
		if (vector_req === 1'b1) begin
			exp_push <= return_pc;
		end
	end
	intc_core dut (.mclk(mclk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.edge_irq_pin(edge_irq_pin), .upper_port_pins(upper_port_pins),
		.timer0_wrap(timer0_wrap), .periph_event(periph_event), .phase(phase),
		.sleep_enter(sleep_enter), .return_from_handler(ret), .return_pc(return_pc),
		.vector_req(vector_req), .vector_pc(vector_pc), .push_pc(push_pc),
		.push_stack(push_stack), .wake_up(wake_up), .sleeping(sleeping));
	intc_cpu_model cpu (.mclk(mclk), .rst(rst), .do_sleep(do_sleep), .do_return(do_return),
		.phase(phase), .sleep_enter(sleep_enter), .return_from_handler(ret),
		.return_pc(return_pc));
	task automatic finish_test;
		$display("checks %0d mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : finish_test
	task automatic chk(input string what, input logic [12:0] exp, input logic [12:0] got);
		check_count++;
		if (got !== exp) begin
			fails++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task automatic bus(input logic wr, input logic [3:0] a, input logic [7:0] d,
		input logic [3:0] be);
		int n;
		n = 0;
		@(posedge mclk);
		avs_address <= a;
		avs_read <= ~wr;
		avs_write <= wr;
		avs_writedata <= {24'h000000, d};
		avs_byteenable <= be;
		@(posedge mclk);
		while (avs_waitrequest !== 1'b0 && n < 20) begin
			@(posedge mclk);
			n++;
		end
		// a slave that never answers is a mismatch, not a silent pass
		if (n >= 20) begin
			fails++;
			$display("CHECK FAILED bus answer expected %h seen %h", 1'b0, avs_waitrequest);
		end
		rd = avs_readdata[7:0];
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask : bus
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		bus(1'b1, a, d, 4'hf);
	endtask : wr
	task automatic rc(input string w, input logic [3:0] a, input logic [7:0] e);
		bus(1'b0, a, 8'h00, 4'hf);
		chk(w, {5'h00, e}, {5'h00, rd});
	endtask : rc
	task automatic ev(input logic t0, input logic [7:0] p, input logic s, input logic r);
		@(posedge mclk);
		timer0_wrap <= t0;
		periph_event <= p;
		do_sleep <= s;
		do_return <= r;
		@(posedge mclk);
		timer0_wrap <= 1'b0;
		periph_event <= 8'h00;
		do_sleep <= 1'b0;
		do_return <= 1'b0;
	endtask : ev
	initial begin
		repeat (3) @(posedge mclk);
		rst <= 1'b0;
		rc("ctrl", `INTC_ADDR_CTRL, `INTC_CTRL_RST);
		rc("pflag", `INTC_ADDR_PFLAG, `INTC_PREG_RST);
		rc("pen", `INTC_ADDR_PEN, `INTC_PREG_RST);
		rc("opt", `INTC_ADDR_OPT, `INTC_OPT_RST);
		rc("unmapped", 4'h2, 8'h00);
		bus(1'b1, `INTC_ADDR_CTRL, 8'h80, 4'he);
		rc("no lane", `INTC_ADDR_CTRL, 8'h00);
		ev(1'b1, 8'h00, 1'b0, 1'b0);
		rc("ctrl", `INTC_ADDR_CTRL, 8'h04);
		chk("vectors", 13'h0000, 13'(n_vec));
		ev(1'b0, 8'hbf, 1'b0, 1'b0);
		rc("pflag", `INTC_ADDR_PFLAG, 8'hbf);
		wr(`INTC_ADDR_PFLAG, 8'h00);
		wr(`INTC_ADDR_CTRL, 8'ha4);
		repeat (16) @(posedge mclk);
		chk("vectors", 13'h0001, 13'(n_vec));
		chk("vector pc", `INTC_VECTOR, vector_pc);
		chk("push pc", exp_push, push_pc);
		rc("ctrl", `INTC_ADDR_CTRL, 8'h24);
		ev(1'b0, 8'h00, 1'b0, 1'b1);
		repeat (16) @(posedge mclk);
		chk("vectors", 13'h0002, 13'(n_vec));
		wr(`INTC_ADDR_CTRL, 8'h20);
		ev(1'b0, 8'h00, 1'b0, 1'b1);
		repeat (16) @(posedge mclk);
		rc("ctrl", `INTC_ADDR_CTRL, 8'ha0);
		wr(`INTC_ADDR_CTRL, 8'h90);
		edge_irq_pin <= 1'b1;
		repeat (16) @(posedge mclk);
		chk("vectors", 13'h0003, 13'(n_vec));
		rc("ctrl", `INTC_ADDR_CTRL, 8'h12);
		wr(`INTC_ADDR_OPT, 8'hbf);
		wr(`INTC_ADDR_CTRL, 8'h00);
		edge_irq_pin <= 1'b0;
		repeat (10) @(posedge mclk);
		rc("ctrl", `INTC_ADDR_CTRL, 8'h02);
		wr(`INTC_ADDR_CTRL, 8'h00);
		edge_irq_pin <= 1'b1;
		upper_port_pins <= 4'h8;
		repeat (10) @(posedge mclk);
		rc("ctrl", `INTC_ADDR_CTRL, 8'h01);
		wr(`INTC_ADDR_CTRL, 8'h40);
		wr(`INTC_ADDR_PEN, 8'h01);
		ev(1'b0, 8'h00, 1'b1, 1'b0);
		repeat (2) @(posedge mclk);
		chk("sleeping", 13'h0001, {12'h000, sleeping});
		ev(1'b0, 8'h01, 1'b0, 1'b0);
		repeat (4) @(posedge mclk);
		chk("sleeping", 13'h0000, {12'h000, sleeping});
		chk("wakes", 13'h0001, 13'(n_wake));
		chk("vectors", 13'h0003, 13'(n_vec));
		rc("pflag", `INTC_ADDR_PFLAG, 8'h01);
		wr(`INTC_ADDR_CTRL, 8'h90);
		ev(1'b0, 8'h00, 1'b1, 1'b0);
		edge_irq_pin <= 1'b0;
		repeat (16) @(posedge mclk);
		chk("wakes", 13'h0002, 13'(n_wake));
		chk("vectors", 13'h0004, 13'(n_vec));
		rst <= 1'b1;
		repeat (2) @(posedge mclk);
		rst <= 1'b0;
		rc("ctrl", `INTC_ADDR_CTRL, `INTC_CTRL_RST);
		finish_test();
	end
	initial begin
		repeat (5000) @(posedge mclk);
		fails++;
		finish_test();
	end
endmodule : intc_core_tb

// File: verification/intc_cpu_model.sv
/* cpu sequencer model: phase count, return address, sleep and return strobes.
   assumes the bench raises do_sleep or do_return for one cycle. */
`timescale 1ns/1ns
module intc_cpu_model (
	// clock and reset
	input wire logic mclk,
	input wire logic rst,
	// bench commands
	input wire logic do_sleep,
	input wire logic do_return,
	// sequencer side
	output logic [1:0] phase,
	output logic sleep_enter,
	output logic return_from_handler,
	output logic [12:0] return_pc
);
	always_ff @(posedge mclk) begin
		if (rst) begin
			phase <= 2'h0;
			return_pc <= 13'h0100;
		end else begin
			phase <= phase + 2'h1;
			if (phase == 2'h3) begin
				return_pc <= return_pc + 13'h0001;
			end
		end
		sleep_enter <= do_sleep;
		return_from_handler <= do_return;
	end
endmodule : intc_cpu_model

// File: verilog/intc_core.sv
// Contract
// RL1 - nine sources: edge pin, timer0, port change, six peripherals; the code has eight peripheral pairs, eleven sources
// RL2 - global enable bit 7 allows unmasked requests, clear blocks all
// RL3 - enabled flag with global enable starts vectoring at once; the code waits for the next first phase, 1-4 mclk cycles
// RL4 - flags set on events regardless of any enable
// RL5 - every reset clears the global enable
// RL6 - taking an interrupt clears global enable, pushes return, loads vector
// RL7 - return from handler sets global enable again
// RL8 - flags stay set until software clears them
// RL9 - pin event to vector takes three or four instruction cycles
// RL10 - edge flag sampled by vectoring logic once per first phase
// RL11 - edge pin rising when polarity bit one, falling when zero
// RL12 - valid edge sets flag bit 1; enable bit 4 gates it
// RL13 - edge event wakes sleep if enabled; global enable picks branch
// RL14 - timer0 wrap sets flag bit 2; enable bit 5 gates it
// RL15 - upper port change sets flag bit 0 with its own enable
// RL16 - peripheral flags and enables in their own register pair
// RL17 - software keeps reserved bit 6 clear on the converterless variant
// RL18 - wake by interrupt leaves the causing flag set
// RL19 - wake with global enable set loads the vector
// RL20 - request is global enable and OR of enabled pairs, no priority
// RL21 - wake with global enable clear resumes after the sleep
/*
 * interrupt controller core of an 8-bit microcontroller: flags, enables, edge
 * detect, vectoring and sleep wake-up, with an avalon-mm register slave.
 * assumes the core supplies a phase count (0 = first phase), a wrap pulse from
 * timer0, peripheral request pulses, and sleep/return strobes.
 */
`timescale 1ns/1ns
`include "intc_cfg.svh"
module intc_core (
	// clock and reset
	input wire logic mclk,
	input wire logic rst,
	// avalon-mm slave
	input wire logic [3:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	// pins
	input wire logic edge_irq_pin,
	input wire logic [3:0] upper_port_pins,
	// on-chip event pulses
	input wire logic timer0_wrap,
	input wire logic [7:0] periph_event,
	// core sequencer
	input wire logic [1:0] phase,
	input wire logic sleep_enter,
	input wire logic return_from_handler,
	input wire logic [12:0] return_pc,
	output logic vector_req,
	output logic [12:0] vector_pc,
	output logic [12:0] push_pc,
	output logic push_stack,
	output logic wake_up,
	output logic sleeping
);
	logic [7:0] ctrl_r;
	logic [7:0] ctrl_nxt;
	logic [7:0] pflag_r;
	logic [7:0] pflag_nxt;
	logic [7:0] pen_r;
	logic [7:0] opt_r;
	logic edge_lvl;
	logic edge_d_r;
	logic [3:0] port_lvl;
	logic [3:0] port_d_r;
	logic ack_r;
	intc_pkg::intc_state_t state_r;
	intc_pkg::intc_state_t state_nxt;

	// pins cross into mclk through four flops
	intc_pin_sync u_edge_sync (
		.mclk(mclk),
		.rst(rst),
		.pin(edge_irq_pin),
		.level(edge_lvl)
	);
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_port
			intc_pin_sync u_port_sync (
				.mclk(mclk),
				.rst(rst),
				.pin(upper_port_pins[gi]),
				.level(port_lvl[gi])
			);
		end
	endgenerate

	// RL11 edge polarity select
	wire rise = edge_lvl & ~edge_d_r;
	wire fall = ~edge_lvl & edge_d_r;
	wire edge_ev = opt_r[`INTC_B_EDGE] ? rise : fall;
	// RL15 any upper pin change
	wire port_ev = |(port_lvl ^ port_d_r);

	// bus decode; one wait cycle, answer on the second cycle
	wire acc = (avs_read | avs_write) & ~ack_r;
	wire wr_ok = avs_write & ack_r & avs_byteenable[0];
	wire sel_ctrl = (avs_address == `INTC_ADDR_CTRL);
	wire sel_pflag = (avs_address == `INTC_ADDR_PFLAG);
	wire sel_pen = (avs_address == `INTC_ADDR_PEN);
	wire sel_opt = (avs_address == `INTC_ADDR_OPT);
	wire [7:0] wbyte = avs_writedata[7:0];
	wire [7:0] rbyte = sel_ctrl ? ctrl_r : sel_pflag ? pflag_r :
		sel_pen ? pen_r : sel_opt ? opt_r : `INTC_ZERO8;

	// RL1 asks nine sources; here three core pairs plus eight peripheral pairs make eleven
	// RL20 no priority: plain OR of enabled pairs
	wire core_pend = (ctrl_r[`INTC_B_EIF] & ctrl_r[`INTC_B_EIE]) |
		(ctrl_r[`INTC_B_T0IF] & ctrl_r[`INTC_B_T0IE]) |
		(ctrl_r[`INTC_B_PCIF] & ctrl_r[`INTC_B_PCIE]);
	wire per_pend = ctrl_r[`INTC_B_PEIE] & (|(pflag_r & pen_r));
	wire any_pend = core_pend | per_pend;
	// RL2 global gate
	wire irq = ctrl_r[`INTC_B_GIE] & any_pend;
	// RL9 RL10 sampled only in the first phase, so vector_req follows an enabled flag by 1-4 mclk cycles
	wire first_ph = (phase == `INTC_PH_FIRST);
	wire take = (state_r == intc_pkg::INTC_RUN) & first_ph & irq;
	wire waking = (state_r == intc_pkg::INTC_SLEEP) & any_pend;

	// control register next value
	always_comb begin
		ctrl_nxt = ctrl_r;
		// RL8 software write clears flags; events below win over it
		if (wr_ok && sel_ctrl) begin
			ctrl_nxt = wbyte;
		end
		// RL7 return re-enables
		if (return_from_handler) begin
			ctrl_nxt[`INTC_B_GIE] = 1'b1;
		end
		// RL6 taking clears global enable
		if (take) begin
			ctrl_nxt[`INTC_B_GIE] = 1'b0;
		end
		// RL4 RL12 edge flag set regardless of enables
		if (edge_ev) begin
			ctrl_nxt[`INTC_B_EIF] = 1'b1;
		end
		// RL14 timer0 wrap flag
		if (timer0_wrap) begin
			ctrl_nxt[`INTC_B_T0IF] = 1'b1;
		end
		if (port_ev) begin
			ctrl_nxt[`INTC_B_PCIF] = 1'b1;
		end
	end

	// RL16 peripheral flags, set wins over clear
	always_comb begin
		pflag_nxt = pflag_r;
		if (wr_ok && sel_pflag) begin
			pflag_nxt = wbyte;
		end
		pflag_nxt = pflag_nxt | periph_event;
	end

	// RL13 RL19 RL21 sleep and wake sequencing
	always_comb begin
		state_nxt = state_r;
		unique case (state_r)
			intc_pkg::INTC_RUN: begin
				if (take) begin
					state_nxt = intc_pkg::INTC_VEC;
				end else if (sleep_enter && !any_pend) begin
					state_nxt = intc_pkg::INTC_SLEEP;
				end
			end
			intc_pkg::INTC_SLEEP: begin
				if (waking) begin
					state_nxt = intc_pkg::INTC_RUN;
				end
			end
			intc_pkg::INTC_VEC: begin
				state_nxt = intc_pkg::INTC_RUN;
			end
			default: begin
				state_nxt = intc_pkg::INTC_RUN;
			end
		endcase
	end

	// RL5 reset clears global enable with the rest of control
	always_ff @(posedge mclk) begin
		if (rst) begin
			ctrl_r <= `INTC_CTRL_RST;
			pflag_r <= `INTC_PREG_RST;
			pen_r <= `INTC_PREG_RST;
			opt_r <= `INTC_OPT_RST;
		end else begin
			ctrl_r <= ctrl_nxt;
			pflag_r <= pflag_nxt;
			if (wr_ok && sel_pen) begin
				pen_r <= wbyte;
			end
			if (wr_ok && sel_opt) begin
				opt_r <= wbyte;
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			edge_d_r <= 1'b0;
			port_d_r <= 4'h0;
			state_r <= intc_pkg::INTC_RUN;
		end else begin
			edge_d_r <= edge_lvl;
			port_d_r <= port_lvl;
			state_r <= state_nxt;
		end
	end

	// bus answer registers
	always_ff @(posedge mclk) begin
		if (rst) begin
			ack_r <= 1'b0;
			avs_readdata <= `INTC_RDATA_DEF;
		end else begin
			ack_r <= acc;
			if (acc) begin
				avs_readdata <= {24'h000000, rbyte};
			end
		end
	end
	assign avs_waitrequest = ~ack_r;

	// RL3 RL6 vector request, push and fixed address
	always_ff @(posedge mclk) begin
		if (rst) begin
			vector_req <= 1'b0;
			push_stack <= 1'b0;
			vector_pc <= `INTC_VECTOR;
			push_pc <= 13'h0000;
			wake_up <= 1'b0;
			sleeping <= 1'b0;
		end else begin
			vector_req <= take;
			push_stack <= take;
			vector_pc <= `INTC_VECTOR;
			if (take) begin
				push_pc <= return_pc;
			end
			// RL18 flags that caused wake are left set
			wake_up <= waking;
			sleeping <= (state_nxt == intc_pkg::INTC_SLEEP);
		end
	end

	// RL2 no vector without global enable
	a_vec_needs_gie: assert property (@(posedge mclk) disable iff (rst)
		vector_req |-> $past(ctrl_r[`INTC_B_GIE])) else $error("vector without gie");
	// RL6 global enable drops after take
	a_take_clears_gie: assert property (@(posedge mclk) disable iff (rst)
		take && !return_from_handler |=> !ctrl_r[`INTC_B_GIE]) else $error("gie kept");
	// RL7 return sets gie
	a_ret_sets_gie: assert property (@(posedge mclk) disable iff (rst)
		return_from_handler && !take |=> ctrl_r[`INTC_B_GIE]) else $error("gie not set");
	// RL4 edge event sets flag
	a_edge_sets_flag: assert property (@(posedge mclk) disable iff (rst)
		edge_ev |=> ctrl_r[`INTC_B_EIF]) else $error("edge flag missed");
	// RL14 timer0 wrap sets flag
	a_t0_sets_flag: assert property (@(posedge mclk) disable iff (rst)
		timer0_wrap |=> ctrl_r[`INTC_B_T0IF]) else $error("timer0 flag missed");
	// RL10 vector only from a first phase
	a_vec_first_phase: assert property (@(posedge mclk) disable iff (rst)
		$rose(vector_req) |-> $past(phase) == `INTC_PH_FIRST) else $error("bad phase");
	// RL3 pending enabled request taken within one instruction cycle
	a_pend_taken: assert property (@(posedge mclk) disable iff (rst)
		(state_r == intc_pkg::INTC_RUN) && irq && !return_from_handler && !avs_write
		|-> ##[0:4] vector_req) else $error("request not taken");
	// RL8 flag stays set unless written
	a_flag_sticky: assert property (@(posedge mclk) disable iff (rst)
		pflag_r[0] && !(wr_ok && sel_pflag) |=> pflag_r[0]) else $error("flag lost");
	// RL6 vector address fixed
	a_vec_address: assert property (@(posedge mclk) disable iff (rst)
		vector_req |-> vector_pc == `INTC_VECTOR && push_stack) else $error("bad vector");
	// RL6 return address pushed with the take
	a_push_on_take: assert property (@(posedge mclk) disable iff (rst)
		take |=> push_stack && push_pc == $past(return_pc)) else $error("push missed");
	// RL13 RL21 enabled pending pair wakes sleep regardless of gie
	a_wake_from_sleep: assert property (@(posedge mclk) disable iff (rst)
		(state_r == intc_pkg::INTC_SLEEP) && any_pend |=> wake_up) else $error("no wake");
	// pending pair turns sleep into a no-op, so no lost wake event
	a_sleep_refused: assert property (@(posedge mclk) disable iff (rst)
		(state_r == intc_pkg::INTC_RUN) && sleep_enter && any_pend |=> !sleeping)
		else $error("slept while pending");
endmodule : intc_core

// File: verilog/intc_pin_sync.sv
/*
 * three-stage pin synchroniser; a change counts once stages two and three agree.
 * assumes the pin is asynchronous to mclk.
 */
`timescale 1ns/1ns
module intc_pin_sync (
	// clock and reset
	input wire logic mclk,
	input wire logic rst,
	// pin and clean level
	input wire logic pin,
	output logic level
);
	logic s1_r;
	logic s2_r;
	logic s3_r;
	wire agree = (s2_r == s3_r);

	always_ff @(posedge mclk) begin
		if (rst) begin
			s1_r <= 1'b0;
			s2_r <= 1'b0;
			s3_r <= 1'b0;
			level <= 1'b0;
		end else begin
			s1_r <= pin;
			s2_r <= s1_r;
			s3_r <= s2_r;
			if (agree) begin
				level <= s3_r;
			end
		end
	end
endmodule : intc_pin_sync
